// ### hw/pwmadt_pkg.sv
// Package: register map, fields, reset values and types of the PWM core
package pwmadt_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_PERIOD_HIGH = 8'hd1;
   localparam logic [7:0] IDX_PERIOD_LOW = 8'hd9;
   localparam logic [7:0] IDX_DUTY_LOW0 = 8'hda;
   localparam logic [7:0] IDX_DUTY_LOW1 = 8'hdb;
   localparam logic [7:0] IDX_DUTY_LOW2 = 8'hdd;
   localparam logic [7:0] IDX_DUTY_LOW3 = 8'hdc;
   localparam logic [7:0] IDX_DUTY_HIGH0 = 8'hd2;
   localparam logic [7:0] IDX_DUTY_HIGH1 = 8'hd3;
   localparam logic [7:0] IDX_DUTY_HIGH2 = 8'hd5;
   localparam logic [7:0] IDX_DUTY_HIGH3 = 8'hd4;
   localparam logic [7:0] IDX_PWM_CONTROL_ONE = 8'hdf;
   localparam logic [7:0] IDX_DEADTIME_ENABLE = 8'hf9;
   localparam logic [7:0] IDX_DEADTIME_COUNT_LOW = 8'hfa;
   localparam logic [7:0] IDX_TIMED_ACCESS = 8'h80;
   localparam logic [7:0] IDX_RUN_CONTROL = 8'h81;
   localparam logic [7:0] IDX_STATUS = 8'h82;
   // Field positions of the control and dead-time enable registers
   localparam int CTL_MODE_LSB = 6;
   localparam int CTL_TYPE_BIT = 4;
   localparam int CTL_DIV_LSB = 0;
   localparam int DTE_CNT8_BIT = 4;
   // Reset value and write masks
   localparam logic [7:0] RST_REG = 8'h00;
   localparam logic [7:0] DTE_MASK = 8'h1f;
   localparam logic [7:0] HIGH_MASK = 8'h0f;
   // Timed-access unlock keys
   localparam logic [7:0] TA_KEY1 = 8'haa;
   localparam logic [7:0] TA_KEY2 = 8'h55;
   // Output modes
   typedef enum logic [1:0] {
      MODE_INDEP = 2'b00,
      MODE_COMPL = 2'b01,
      MODE_SYNC = 2'b10,
      MODE_RSVD = 2'b11
   } pwmadt_mode_e;
   // Timed-access sequencer states
   typedef enum logic [1:0] {
      TA_IDLE = 2'b00,
      TA_KEYED = 2'b01,
      TA_OPEN = 2'b10
   } pwmadt_ta_e;
   // Decoded configuration carried to the waveform logic
   typedef struct packed {
      pwmadt_mode_e mode;
      logic center;
      logic [2:0] div;
      logic [11:0] period;
      logic [3:0] dt_en;
      logic [8:0] dt_cnt;
   } pwmadt_cfg_s;
   // Captured AHB address phase
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] idx;
   } pwmadt_req_s;
endpackage

// ### hw/pwmadt_core.sv
// PWM core: AHB-Lite registers, period counter, generators, mode stage, dead time
`timescale 1ns/1ps
module pwmadt_core #(
   parameter int NPAIR = 4,
   parameter int CW = 12
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // PWM channel outputs to the half bridges
   output logic [2*NPAIR-1:0] pwm_out
);

   ////////////////////////////////////////////////////////////////////////
   // Register storage
   logic [7:0] period_low_ff;
   logic [7:0] period_high_ff;
   logic [7:0] duty_low_ff [NPAIR];
   logic [7:0] duty_high_ff [NPAIR];
   logic [7:0] pwm_control_one_ff;
   logic [7:0] deadtime_enable_ff;
   logic [7:0] deadtime_count_low_ff;
   logic run_ff;
   pwmadt_pkg::pwmadt_ta_e ta_ff;
   pwmadt_pkg::pwmadt_req_s req_ff;
   logic rd_wait_ff;
   logic [31:0] hrdata_ff;
   pwmadt_pkg::pwmadt_cfg_s cfg;
   logic [CW-1:0] cnt_ff;
   logic down_ff;
   logic [6:0] div_ff;
   logic tick;
   logic [NPAIR-1:0] gen_ff;
   logic [2*NPAIR-1:0] want;
   logic addr_ok;
   logic [7:0] wdat;
   logic prot_ok;
   logic [31:0] nxt_rdata;

   ////////////////////////////////////////////////////////////////////////
   // Bus front end
   // Address phase taken when selected, ready and transfer is NONSEQ/SEQ
   assign addr_ok = hsel && hready && htrans[1];
   assign wdat = hwdata[7:0];
   assign hresp = 1'b0;
   assign hreadyout = ~rd_wait_ff;
   assign hrdata = hrdata_ff;
   // Protected registers accept a write only while the unlock is open
   assign prot_ok = (ta_ff == pwmadt_pkg::TA_OPEN);

   // Capture of the address phase; hsize is always a word here
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         req_ff <= '0;
      end else if (hready) begin
         req_ff.wr <= addr_ok && hwrite;
         req_ff.rd <= addr_ok && !hwrite;
         req_ff.idx <= haddr[9:2];
      end
   end

   // One wait state on reads so the answer follows any earlier write
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_wait_ff <= 1'b0;
      end else begin
         rd_wait_ff <= addr_ok && !hwrite;
      end
   end

   // Read multiplexer; unmapped addresses read as zero
   always_comb begin
      nxt_rdata = 32'h0000_0000;
      unique case (req_ff.idx)
         pwmadt_pkg::IDX_PERIOD_LOW: nxt_rdata[7:0] = period_low_ff;
         pwmadt_pkg::IDX_PERIOD_HIGH: nxt_rdata[7:0] = period_high_ff;
         pwmadt_pkg::IDX_DUTY_LOW0: nxt_rdata[7:0] = duty_low_ff[0];
         pwmadt_pkg::IDX_DUTY_LOW1: nxt_rdata[7:0] = duty_low_ff[1];
         pwmadt_pkg::IDX_DUTY_LOW2: nxt_rdata[7:0] = duty_low_ff[2];
         pwmadt_pkg::IDX_DUTY_LOW3: nxt_rdata[7:0] = duty_low_ff[3];
         pwmadt_pkg::IDX_DUTY_HIGH0: nxt_rdata[7:0] = duty_high_ff[0];
         pwmadt_pkg::IDX_DUTY_HIGH1: nxt_rdata[7:0] = duty_high_ff[1];
         pwmadt_pkg::IDX_DUTY_HIGH2: nxt_rdata[7:0] = duty_high_ff[2];
         pwmadt_pkg::IDX_DUTY_HIGH3: nxt_rdata[7:0] = duty_high_ff[3];
         pwmadt_pkg::IDX_PWM_CONTROL_ONE: nxt_rdata[7:0] = pwm_control_one_ff;
         pwmadt_pkg::IDX_DEADTIME_ENABLE: nxt_rdata[7:0] = deadtime_enable_ff;
         pwmadt_pkg::IDX_DEADTIME_COUNT_LOW: nxt_rdata[7:0] = deadtime_count_low_ff;
         pwmadt_pkg::IDX_RUN_CONTROL: nxt_rdata[0] = run_ff;
         pwmadt_pkg::IDX_STATUS: nxt_rdata[13:0] = {prot_ok, down_ff, cnt_ff};
         default: nxt_rdata = 32'h0000_0000;
      endcase
   end

   // Read data register, loaded in the wait cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_ff <= 32'h0000_0000;
      end else if (rd_wait_ff) begin
         hrdata_ff <= nxt_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register writes in the data phase
   // Unprotected registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         period_low_ff <= pwmadt_pkg::RST_REG;
         period_high_ff <= pwmadt_pkg::RST_REG;
         pwm_control_one_ff <= pwmadt_pkg::RST_REG;
         run_ff <= 1'b0;
      end else if (req_ff.wr) begin
         unique case (req_ff.idx)
            pwmadt_pkg::IDX_PERIOD_LOW: period_low_ff <= wdat;
            pwmadt_pkg::IDX_PERIOD_HIGH: period_high_ff <= wdat & pwmadt_pkg::HIGH_MASK;
            pwmadt_pkg::IDX_PWM_CONTROL_ONE: pwm_control_one_ff <= wdat;
            pwmadt_pkg::IDX_RUN_CONTROL: run_ff <= wdat[0];
            default: ;
         endcase
      end
   end

   // Duty registers, one pair per loop step
   for (genvar p = 0; p < NPAIR; p++) begin : g_duty
      localparam logic [7:0] LO_IDX = (p == 0) ? pwmadt_pkg::IDX_DUTY_LOW0 :
         (p == 1) ? pwmadt_pkg::IDX_DUTY_LOW1 :
         (p == 2) ? pwmadt_pkg::IDX_DUTY_LOW2 : pwmadt_pkg::IDX_DUTY_LOW3;
      localparam logic [7:0] HI_IDX = (p == 0) ? pwmadt_pkg::IDX_DUTY_HIGH0 :
         (p == 1) ? pwmadt_pkg::IDX_DUTY_HIGH1 :
         (p == 2) ? pwmadt_pkg::IDX_DUTY_HIGH2 : pwmadt_pkg::IDX_DUTY_HIGH3;
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            duty_low_ff[p] <= pwmadt_pkg::RST_REG;
            duty_high_ff[p] <= pwmadt_pkg::RST_REG;
         end else if (req_ff.wr && req_ff.idx == LO_IDX) begin
            duty_low_ff[p] <= wdat;
         end else if (req_ff.wr && req_ff.idx == HI_IDX) begin
            duty_high_ff[p] <= wdat & pwmadt_pkg::HIGH_MASK;
         end
      end
   end

   // Dead-time registers, writable only through the open unlock
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         deadtime_enable_ff <= pwmadt_pkg::RST_REG;
         deadtime_count_low_ff <= pwmadt_pkg::RST_REG;
      end else if (req_ff.wr && prot_ok) begin
         if (req_ff.idx == pwmadt_pkg::IDX_DEADTIME_ENABLE) begin
            deadtime_enable_ff <= wdat & pwmadt_pkg::DTE_MASK;
         end else if (req_ff.idx == pwmadt_pkg::IDX_DEADTIME_COUNT_LOW) begin
            deadtime_count_low_ff <= wdat;
         end
      end
   end

   // Timed-access sequencer: two keys open the next single write
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ta_ff <= pwmadt_pkg::TA_IDLE;
      end else if (req_ff.wr) begin
         if (req_ff.idx == pwmadt_pkg::IDX_TIMED_ACCESS && wdat == pwmadt_pkg::TA_KEY1) begin
            ta_ff <= pwmadt_pkg::TA_KEYED;
         end else if (req_ff.idx == pwmadt_pkg::IDX_TIMED_ACCESS && wdat == pwmadt_pkg::TA_KEY2
                      && ta_ff == pwmadt_pkg::TA_KEYED) begin
            ta_ff <= pwmadt_pkg::TA_OPEN;
         end else begin
            ta_ff <= pwmadt_pkg::TA_IDLE;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Configuration decode
   always_comb begin
      cfg.mode = pwmadt_pkg::pwmadt_mode_e'(pwm_control_one_ff[pwmadt_pkg::CTL_MODE_LSB +: 2]);
      cfg.center = pwm_control_one_ff[pwmadt_pkg::CTL_TYPE_BIT];
      cfg.div = pwm_control_one_ff[pwmadt_pkg::CTL_DIV_LSB +: 3];
      cfg.period = {period_high_ff[3:0], period_low_ff};
      cfg.dt_en = deadtime_enable_ff[3:0];
      cfg.dt_cnt = {deadtime_enable_ff[pwmadt_pkg::DTE_CNT8_BIT], deadtime_count_low_ff};
   end

   ////////////////////////////////////////////////////////////////////////
   // Prescaler: one tick every 2^div clocks; >= lets a smaller divide act at once
   assign tick = run_ff && (div_ff >= 7'((8'h01 << cfg.div) - 8'h01));

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_ff <= 7'h00;
      end else if (!run_ff || tick) begin
         div_ff <= 7'h00;
      end else begin
         div_ff <= div_ff + 7'h01;
      end
   end

   // Period counter, single or dual slope
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_ff <= '0;
         down_ff <= 1'b0;
      end else if (!run_ff) begin
         cnt_ff <= '0;
         down_ff <= 1'b0;
      end else if (tick) begin
         if (!cfg.center) begin
            down_ff <= 1'b0;
            cnt_ff <= (cnt_ff >= cfg.period) ? '0 : cnt_ff + 1'b1;
         end else if (!down_ff) begin
            if (cnt_ff >= cfg.period) begin
               down_ff <= (cfg.period != '0);
               cnt_ff <= (cfg.period != '0) ? cnt_ff - 1'b1 : '0;
            end else begin
               cnt_ff <= cnt_ff + 1'b1;
            end
         end else begin
            if (cnt_ff == '0 || cnt_ff == CW'(1)) begin
               down_ff <= 1'b0;
            end
            cnt_ff <= (cnt_ff == '0) ? CW'(1) : cnt_ff - 1'b1; // Period one bounces
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Generators and output stage per pair
   for (genvar p = 0; p < NPAIR; p++) begin : g_pair
      logic [CW-1:0] duty;
      logic [8:0] dt_ff;
      logic busy_ff;
      logic dt_on;
      logic odd_src;
      logic [1:0] want_d_ff;
      logic chg;
      logic hold;
      assign duty = {duty_high_ff[p][3:0], duty_low_ff[p]};

      // Generator: set at zero/down-match, clear at match (clear wins)
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            gen_ff[p] <= 1'b0;
         end else if (!run_ff) begin
            gen_ff[p] <= 1'b0;
         end else if (!cfg.center) begin
            if (cnt_ff == duty) begin
               gen_ff[p] <= 1'b0;
            end else if (cnt_ff == '0) begin
               gen_ff[p] <= 1'b1;
            end
         end else if (cnt_ff == duty) begin
            gen_ff[p] <= down_ff;
         end
      end

      // Mode stage; even output of each pair passes its generator straight through
      always_comb begin
         unique case (cfg.mode)
            pwmadt_pkg::MODE_COMPL: odd_src = ~gen_ff[p];
            pwmadt_pkg::MODE_SYNC: odd_src = gen_ff[p];
            default: odd_src = 1'b1;
         endcase
         want[2*p] = gen_ff[p];
         want[2*p+1] = odd_src;
      end

      // Dead time only in complementary mode with the pair enabled
      assign dt_on = (cfg.mode == pwmadt_pkg::MODE_COMPL) && cfg.dt_en[p];

      // Restart on a change of wanted levels only; a held output must not reload
      assign chg = (want[2*p+1 -: 2] != want_d_ff);
      assign hold = chg || (busy_ff && dt_ff != 9'h000);

      // Previous wanted levels; reset to the idle levels, odd high, even low
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            want_d_ff <= 2'h2;
         end else begin
            want_d_ff <= want[2*p+1 -: 2];
         end
      end

      // Down-counter loaded on a change, counts to zero
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            dt_ff <= 9'h000;
            busy_ff <= 1'b0;
         end else if (!dt_on) begin
            busy_ff <= 1'b0;
            dt_ff <= 9'h000;
         end else if (chg) begin
            busy_ff <= 1'b1;
            dt_ff <= cfg.dt_cnt;
         end else if (busy_ff) begin
            busy_ff <= (dt_ff != 9'h000);
            dt_ff <= (dt_ff != 9'h000) ? dt_ff - 9'h001 : 9'h000;
         end
      end

      // Rising edges held count+1 clocks; falling edges pass at once
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            pwm_out[2*p+1 -: 2] <= 2'h0;
         end else if (dt_on) begin
            pwm_out[2*p] <= want[2*p] & (pwm_out[2*p] | ~hold);
            pwm_out[2*p+1] <= want[2*p+1] & (pwm_out[2*p+1] | ~hold);
         end else begin
            pwm_out[2*p] <= want[2*p];
            pwm_out[2*p+1] <= want[2*p+1];
         end
      end
   end

   // Unused bus inputs kept visible to lint by a harmless reduction
   logic unused_bits;
   assign unused_bits = ^{hsize, haddr[31:10], haddr[1:0], hwdata[31:8]};

endmodule

// ### test/pwmadt_core_checker.sv
// Checker: bus timing and output-mode relations of the PWM core
`timescale 1ns/1ps
module pwmadt_core_checker #(
   parameter int NPAIR = 4,
   parameter int CW = 12
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   // Channel outputs
   input wire logic [2*NPAIR-1:0] pwm_out
);
   logic ctl_pend_ff;
   logic [1:0] mode_ff;
   logic [2:0] age_ff;
   logic [NPAIR-1:0] odd_v;
   logic [NPAIR-1:0] even_v;
   ////////////////////////////////////////////////////////////////////////////////
   // Split channels into even and odd halves of each pair
   always_comb begin
      for (int p = 0; p < NPAIR; p++) begin
         odd_v[p] = pwm_out[2*p+1];
         even_v[p] = pwm_out[2*p];
      end
   end
   // Note a control write in its address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctl_pend_ff <= 1'b0;
      end else if (hready) begin
         ctl_pend_ff <= hsel && htrans[1] && hwrite && haddr[9:2] == pwmadt_pkg::IDX_PWM_CONTROL_ONE;
      end
   end
   // Shadow mode and cycles since the last control write, saturating at 7
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_ff <= 2'h0;
         age_ff <= 3'h0;
      end else if (ctl_pend_ff && hready) begin
         mode_ff <= hwdata[7:6];
         age_ff <= 3'h0;
      end else if (age_ff != 3'h7) begin
         age_ff <= age_ff + 3'h1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_read_taken;
      hsel && hready && htrans[1] && !hwrite;
   endsequence
   sequence s_write_taken;
      hsel && hready && htrans[1] && hwrite;
   endsequence
   sequence s_read_answer;
      !hreadyout ##1 hreadyout;
   endsequence
   a_read_wait: assert property (s_read_taken |=> s_read_answer)
      else $error("read data phase timing wrong");
   a_write_nowait: assert property (s_write_taken |=> hreadyout)
      else $error("write data phase stalled");
   a_unmapped_zero: assert property ((s_read_taken ##0 haddr[9:2] == 8'h10) |-> ##2 hrdata == 32'h0)
      else $error("unmapped read not zero");
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("response not okay");
   a_indep_odd_high: assert property (mode_ff == 2'b00 && age_ff == 3'h7 |-> &odd_v)
      else $error("odd channel low in independent mode");
   a_rsvd_odd_high: assert property (mode_ff == 2'b11 && age_ff == 3'h7 |-> (&odd_v) [*2])
      else $error("odd channel low in reserved mode");
   a_sync_in_phase: assert property (mode_ff == 2'b10 && age_ff == 3'h7 |-> odd_v == even_v)
      else $error("synchronous pair differs");
   a_compl_no_overlap: assert property (mode_ff == 2'b01 && age_ff == 3'h7 |-> (odd_v & even_v) == '0)
      else $error("complementary pair both high");
endmodule
bind pwmadt_core pwmadt_core_checker #(.NPAIR(NPAIR), .CW(CW)) chk_u (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
   .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pwm_out(pwm_out));

// ### test/pwmadt_bridge_model.sv
// Half-bridge load model: on-time, rise and shoot-through counters
`timescale 1ns/1ps
module pwmadt_bridge_model (
   // Clock and counter clear
   input wire logic hclk,
   input wire logic clr,
   // Gate drives
   input wire logic [7:0] pwm_out,
   // Observations
   output logic [7:0][15:0] hi_cnt,
   output logic [15:0] rise_cnt,
   output logic [15:0] shoot_cnt
);
   logic prev_ff;
   // Accumulate switch on-time, channel 0 turn-ons and pair overlaps
   always_ff @(posedge hclk) begin
      prev_ff <= pwm_out[0];
      if (clr) begin
         hi_cnt <= '0;
         rise_cnt <= '0;
         shoot_cnt <= '0;
      end else begin
         for (int c = 0; c < 8; c++) begin
            hi_cnt[c] <= hi_cnt[c] + 16'(pwm_out[c]);
         end
         rise_cnt <= rise_cnt + 16'(pwm_out[0] && !prev_ff);
         shoot_cnt <= shoot_cnt + 16'(|(pwm_out[7:0] & {pwm_out[6:0], 1'b0} & 8'haa));
      end
   end
endmodule

// ### test/testbench.sv
// Testbench: register access, waveform types, output modes and dead time
`timescale 1ns/1ps
module testbench;
   logic hclk, hresetn, hsel, hwrite, clr, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [7:0] pwm_out;
   logic [7:0][15:0] hi_cnt;
   logic [15:0] rise_cnt, shoot_cnt;
   logic [7:0] duty_lo [4] = '{pwmadt_pkg::IDX_DUTY_LOW0, pwmadt_pkg::IDX_DUTY_LOW1,
      pwmadt_pkg::IDX_DUTY_LOW2, pwmadt_pkg::IDX_DUTY_LOW3};
   logic [7:0] duty_hi [4] = '{pwmadt_pkg::IDX_DUTY_HIGH0, pwmadt_pkg::IDX_DUTY_HIGH1,
      pwmadt_pkg::IDX_DUTY_HIGH2, pwmadt_pkg::IDX_DUTY_HIGH3};
   int fails, comparisons;
   ////////////////////////////////////////////////////////////////////////////////
   // Design, load model and clock
   pwmadt_core dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .pwm_out(pwm_out));
   pwmadt_bridge_model load_u (.hclk(hclk), .clr(clr), .pwm_out(pwm_out), .hi_cnt(hi_cnt),
      .rise_cnt(rise_cnt), .shoot_cnt(shoot_cnt));
   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Compare and count
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // One single AHB-Lite transfer
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                      output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= {22'h0, idx, 2'b00};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h0, wd};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] rd;
      bus(1'b1, idx, d, rd);
   endtask
   task automatic rdchk(input string name, input logic [7:0] idx, input logic [31:0] exp);
      logic [31:0] rd;
      bus(1'b0, idx, 8'h00, rd);
      check(name, rd, exp);
   endtask
   // Unlock sequence followed by the protected write
   task automatic unlock_wr(input logic [7:0] idx, input logic [7:0] d);
      wr(pwmadt_pkg::IDX_TIMED_ACCESS, pwmadt_pkg::TA_KEY1);
      wr(pwmadt_pkg::IDX_TIMED_ACCESS, pwmadt_pkg::TA_KEY2);
      wr(idx, d);
   endtask
   // Period and equal duty on every pair
   task automatic set_wave(input logic [11:0] per, input logic [11:0] duty);
      wr(pwmadt_pkg::IDX_PERIOD_LOW, per[7:0]);
      wr(pwmadt_pkg::IDX_PERIOD_HIGH, {4'h0, per[11:8]});
      for (int p = 0; p < 4; p++) begin
         wr(duty_lo[p], duty[7:0]);
         wr(duty_hi[p], {4'h0, duty[11:8]});
      end
   endtask
   // Let the waveform settle, then count over a window
   task automatic measure(input int cyc);
      repeat (64) @(posedge hclk);
      clr <= 1'b1;
      @(posedge hclk);
      clr <= 1'b0;
      repeat (cyc) @(posedge hclk);
      #1;
   endtask
   task automatic conclude();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Watchdog
   initial begin
      #200000;
      fails++;
      conclude();
   end
   // Main sequence
   initial begin
      logic [8:0] n;
      static logic [7:0] rst_idx [3] = '{pwmadt_pkg::IDX_PWM_CONTROL_ONE,
         pwmadt_pkg::IDX_DEADTIME_ENABLE,
         pwmadt_pkg::IDX_DEADTIME_COUNT_LOW};
      fails = 0;
      comparisons = 0;
      {hsel, hwrite, clr, hresetn} = 4'h0;
      haddr = '0;
      hwdata = '0;
      htrans = 2'b00;
      hsize = 3'b010;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      for (int i = 0; i < 3; i++) rdchk("reset value", rst_idx[i], 32'h0);
      wr(8'h10, 8'hff);
      rdchk("unmapped", 8'h10, 32'h0);
      wr(pwmadt_pkg::IDX_PERIOD_HIGH, 8'hff);
      rdchk("period high", pwmadt_pkg::IDX_PERIOD_HIGH, 32'h0f);
      wr(pwmadt_pkg::IDX_DEADTIME_ENABLE, 8'hff);
      rdchk("locked enable", pwmadt_pkg::IDX_DEADTIME_ENABLE, 32'h0);
      unlock_wr(pwmadt_pkg::IDX_DEADTIME_ENABLE, 8'hff);
      rdchk("unlocked enable", pwmadt_pkg::IDX_DEADTIME_ENABLE, 32'h1f);
      unlock_wr(pwmadt_pkg::IDX_DEADTIME_ENABLE, 8'h00);
      wr(pwmadt_pkg::IDX_PWM_CONTROL_ONE, 8'hff);
      rdchk("control", pwmadt_pkg::IDX_PWM_CONTROL_ONE, 32'hff);
      // Edge-aligned, each output mode
      set_wave(12'h003, 12'h002);
      wr(pwmadt_pkg::IDX_RUN_CONTROL, 8'h01);
      for (int m = 0; m < 4; m++) begin
         wr(pwmadt_pkg::IDX_PWM_CONTROL_ONE, {2'(m), 6'h00});
         measure(64);
         check("even on-time", hi_cnt[0], 32'd32);
         check("odd on-time", hi_cnt[1], (m == 1 || m == 2) ? 32'd32 : 32'd64);
         check("overlap", shoot_cnt, (m == 1) ? 32'd0 : 32'd32);
      end
      // Prescaler scales the period
      for (int d = 0; d < 4; d++) begin
         wr(pwmadt_pkg::IDX_PWM_CONTROL_ONE, {5'h00, 3'(d)});
         measure(256);
         check("edge periods", rise_cnt, 32'd64 >> d);
      end
      // Center-aligned: period twice the count, duty over period
      set_wave(12'h004, 12'h002);
      wr(pwmadt_pkg::IDX_PWM_CONTROL_ONE, 8'h10);
      measure(64);
      check("center on-time", hi_cnt[0], 32'd32);
      check("center periods", rise_cnt, 32'd8);
      // Dead time on pair 0 only, short and 9-bit counts
      for (int k = 0; k < 2; k++) begin
         n = (k == 0) ? 9'd3 : 9'd259;
         wr(pwmadt_pkg::IDX_RUN_CONTROL, 8'h00);
         set_wave(12'h3ff, 12'h200);
         unlock_wr(pwmadt_pkg::IDX_DEADTIME_COUNT_LOW, n[7:0]);
         unlock_wr(pwmadt_pkg::IDX_DEADTIME_ENABLE, {3'h0, n[8], 4'h1});
         wr(pwmadt_pkg::IDX_PWM_CONTROL_ONE, 8'h40);
         wr(pwmadt_pkg::IDX_RUN_CONTROL, 8'h01);
         measure(2048);
         check("delayed even", hi_cnt[0], 32'd1024 - 32'd2 * (n + 9'd1));
         check("delayed odd", hi_cnt[1], 32'd1024 - 32'd2 * (n + 9'd1));
         check("plain even", hi_cnt[2], 32'd1024);
         check("plain odd", hi_cnt[3], 32'd1024);
         check("dead overlap", shoot_cnt, 32'd0);
         wr(pwmadt_pkg::IDX_PWM_CONTROL_ONE, 8'h80);
         measure(2048);
         check("sync even", hi_cnt[0], 32'd1024);
         check("sync odd", hi_cnt[1], 32'd1024);
      end
      // Stopped counter, open unlock and one duty readback
      wr(pwmadt_pkg::IDX_RUN_CONTROL, 8'h00);
      rdchk("status idle", pwmadt_pkg::IDX_STATUS, 32'h0);
      wr(pwmadt_pkg::IDX_TIMED_ACCESS, pwmadt_pkg::TA_KEY1);
      wr(pwmadt_pkg::IDX_TIMED_ACCESS, pwmadt_pkg::TA_KEY2);
      rdchk("status open", pwmadt_pkg::IDX_STATUS, 32'h2000);
      wr(duty_lo[2], 8'h5a);
      rdchk("duty low", duty_lo[2], 32'h5a);
      conclude();
   end
endmodule
